// ==== hw/rate_gen_consts.vh ====
// Purpose: Offsets, field positions and reset values of the bit-rate generator
// Assumes: 32-bit AXI4-Lite register words, one aligned word per register
// Notes:   Definitions only
`ifndef RATE_GEN_CONSTS_VH
`define RATE_GEN_CONSTS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define OFS_TX_CTRL      4'h0
`define OFS_RX_CTRL      4'h4
`define OFS_RATE_CTRL    4'h8
`define OFS_DIV_HIGH     4'hc
`define ADDR_BITS        4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_MASTER_SEL   7
`define BIT_SYNC_SEL     4
`define BIT_HIGH_SPEED   2
`define BIT_PORT_EN      7
`define BIT_WIDE_DIV     3
`define BIT_DIV_LOW_WORD 8

// ----------------------------------------------------------------
// Reset values and prescales
// ----------------------------------------------------------------
`define RST_TX_CTRL      8'h02
`define RST_RX_CTRL      8'h00
`define RST_RATE_CTRL    8'h40
`define RST_DIV          8'h00
`define TX_CTRL_WMASK    8'hfd
`define RX_CTRL_WMASK    8'hf8
`define RATE_CTRL_WMASK  8'h9b
`define PRE_SLOW         7'h40
`define PRE_FAST         7'h10
`define PRE_SYNC         7'h04

`endif

// ==== hw/majority_sampler.v ====
// Purpose: Takes three samples of the receive level per bit and votes
// Assumes: rx_in already synchronised to clk
// Notes:   single_mode passes the middle sample straight through
`timescale 1ns/1ps
`default_nettype none
module majority_sampler (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       sample_en,
    input  wire       bit_end,
    input  wire       single_mode,
    input  wire       rx_in,
    output reg        rx_bit
);
    reg [1:0] cnt_q;
    reg [2:0] smp_q;
    wire      vote;

    assign vote = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);

    always @(posedge clk) begin
        if (!rst_b) begin
            cnt_q  <= 2'h0;
            smp_q  <= 3'h7;
            rx_bit <= 1'b1;
        end else begin
            if (sample_en && cnt_q != 2'h3) begin
                smp_q[cnt_q] <= rx_in;
                cnt_q        <= cnt_q + 2'h1;
            end
            if (bit_end) begin
                cnt_q  <= 2'h0;
                // Single mode uses only the sample from the middle slot
                rx_bit <= single_mode ? smp_q[1] : vote;
            end
        end
    end
endmodule // majority_sampler
`default_nettype wire

// ==== hw/rate_gen.v ====
// Purpose: Bit-rate generator with receive-level sampling, AXI4-Lite registers
// Assumes: clk is the device clock; divisor never programmed to zero
// Notes:   Framing, auto-rate detection and wake-up live elsewhere
//
// Contract
// - Bit rate derives only from the device clock; clock change changes rate.
// - Asynchronous, not both speed selects: three samples per bit, majority vote.
// - Synchronous, or both speed selects set: one sample per bit.
// - Async, 8-bit, low speed: rate is clock over 64 times divisor plus one.
// - Async one select set: over 16(n+1); synchronous: over 4(n+1).
// - Divisor is high byte above low byte, a 16-bit reload value.
// - Narrow mode uses low byte only; wide select uses both; default narrow.
// - Any divisor byte write clears the rate counter one clock after the byte updates.
// - Formulas apply in master or async; slave takes clock from remote.
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rate_gen_consts.vh"
module rate_gen (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    input  wire [31:0] s_axi_araddr,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    input  wire        rx_pin,
    output reg         bit_tick,
    output reg         rx_level
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [7:0]  tx_ctrl_q;
    reg  [7:0]  rx_ctrl_q;
    reg  [7:0]  rate_ctrl_q;
    reg  [7:0]  div_high_q;
    reg  [7:0]  div_low_q;
    reg         aw_held_q;
    reg         w_held_q;
    reg  [3:0]  aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg         rx_meta_q;
    reg         rx_sync_q;
    reg  [15:0] count_q;
    reg  [6:0]  pre_q;
    reg  [6:0]  pre_sel;
    reg         aw_bad_q;
    reg         div_wr;
    reg  [31:0] rd_word;
    wire        sync_mode;
    wire        hs;
    wire        wide;
    wire        single_mode;
    wire        run;
    wire [15:0] reload;
    wire        pre_wrap;
    wire        cnt_wrap;
    wire        sample_en;
    wire        voted;
    wire        do_write;
    wire [6:0]  quarter;
    wire        rd_bad;

    assign sync_mode   = tx_ctrl_q[`BIT_SYNC_SEL];
    assign hs          = tx_ctrl_q[`BIT_HIGH_SPEED];
    assign wide        = rate_ctrl_q[`BIT_WIDE_DIV];
    assign single_mode = sync_mode | (hs & wide);
    // Slave mode: the remote party clocks the link, so no tick here
    assign run         = rx_ctrl_q[`BIT_PORT_EN] &
                         (~sync_mode | tx_ctrl_q[`BIT_MASTER_SEL]);
    assign reload      = wide ? {div_high_q, div_low_q} : {8'h00, div_low_q};
    assign do_write    = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign rd_bad      = (s_axi_araddr[31:4] != 28'h0000000) || (s_axi_araddr[1:0] != 2'b00);

    // ----------------------------------------------------------------
    // Prescale choice
    // ----------------------------------------------------------------
    always @* begin
        if (sync_mode)
            pre_sel = `PRE_SYNC;
        else if (hs & wide)
            pre_sel = `PRE_SYNC;
        else if (hs | wide)
            pre_sel = `PRE_FAST;
        else
            pre_sel = `PRE_SLOW;
    end

    // Period is prescale times (n+1) device clocks, nothing else
    // Wrap on >= so a mode change that shrinks a limit cannot strand a counter
    assign pre_wrap  = (pre_q >= pre_sel - 7'h01);
    assign cnt_wrap  = pre_wrap && (count_q >= reload);
    // Three strobes a quarter apart in the middle count step; second is the single sample
    assign quarter   = {2'b00, pre_sel[6:2]};
    assign sample_en = run && (count_q == {1'b0, reload[15:1]}) &&
                       (pre_q == quarter - 7'h01 ||
                        pre_q == {quarter[5:0], 1'b0} - 7'h01 ||
                        pre_q == quarter + {quarter[5:0], 1'b0} - 7'h01);

    // ----------------------------------------------------------------
    // Rate counter
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            pre_q    <= 7'h00;
            count_q  <= 16'h0000;
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= 1'b0;
            if (div_wr || !run) begin
                pre_q   <= 7'h00;
                count_q <= 16'h0000;
            end else if (pre_wrap) begin
                pre_q <= 7'h00;
                if (count_q >= reload) begin
                    count_q  <= 16'h0000;
                    bit_tick <= 1'b1;
                end else begin
                    count_q <= count_q + 16'h0001;
                end
            end else begin
                pre_q <= pre_q + 7'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive pin synchroniser and sampler
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_level  <= 1'b1;
        end else begin
            rx_meta_q <= rx_pin;
            rx_sync_q <= rx_meta_q;
            rx_level  <= voted;
        end
    end

    majority_sampler u_sampler (
        .clk         (clk),
        .rst_b       (rst_b),
        .sample_en   (sample_en),
        .bit_end     (cnt_wrap),
        .single_mode (single_mode),
        .rx_in       (rx_sync_q),
        .rx_bit      (voted)
    );

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 4'h0;
            aw_bad_q      <= 1'b0;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            tx_ctrl_q     <= `RST_TX_CTRL;
            rx_ctrl_q     <= `RST_RX_CTRL;
            rate_ctrl_q   <= `RST_RATE_CTRL;
            div_high_q    <= `RST_DIV;
            div_low_q     <= `RST_DIV;
            div_wr        <= 1'b0;
        end else begin
            div_wr <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr[3:0];
                aw_bad_q      <= (s_axi_awaddr[31:4] != 28'h0000000) ||
                                 (s_axi_awaddr[1:0] != 2'b00);
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                if (aw_bad_q) begin
                    // Unmapped or misaligned: refused, no register touched
                    s_axi_bresp <= 2'b10;
                end else begin
                    if (w_strb_q[0]) begin
                        case (aw_addr_q)
                            `OFS_TX_CTRL: tx_ctrl_q <= (w_data_q[7:0] & `TX_CTRL_WMASK) |
                                                       (tx_ctrl_q & ~`TX_CTRL_WMASK);
                            `OFS_RX_CTRL: rx_ctrl_q <= w_data_q[7:0] & `RX_CTRL_WMASK;
                            `OFS_RATE_CTRL: rate_ctrl_q <= (w_data_q[7:0] & `RATE_CTRL_WMASK) |
                                                           (rate_ctrl_q & ~`RATE_CTRL_WMASK);
                            `OFS_DIV_HIGH: begin
                                div_high_q <= w_data_q[7:0];
                                div_wr     <= 1'b1;
                            end
                            default: s_axi_bresp <= 2'b10;
                        endcase
                    end
                    // Low byte sits in byte lane 1 of the divisor word
                    if (aw_addr_q == `OFS_DIV_HIGH && w_strb_q[1]) begin
                        div_low_q <= w_data_q[`BIT_DIV_LOW_WORD +: 8];
                        div_wr    <= 1'b1;
                    end
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    always @* begin
        case (s_axi_araddr[3:0])
            `OFS_TX_CTRL:   rd_word = {24'h000000, tx_ctrl_q};
            `OFS_RX_CTRL:   rd_word = {24'h000000, rx_ctrl_q};
            // Receive-idle bit shows the live voted line level
            `OFS_RATE_CTRL: rd_word = {24'h000000, rate_ctrl_q[7], rx_level, rate_ctrl_q[5:0]};
            `OFS_DIV_HIGH:  rd_word = {16'h0000, div_low_q, div_high_q};
            default:        rd_word = 32'h00000000;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_bad ? 32'h00000000 : rd_word;
            s_axi_rresp   <= rd_bad ? 2'b10 : 2'b00;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // rate_gen
`default_nettype wire

// ==== testbench/remote_line.sv ====
// Purpose: Far-end transmitter that drives the receive line
// Assumes: Line rests at the mark level
// Notes:   Holds a space level only while the bench asks for it
`timescale 1ns/1ps
`default_nettype none
module remote_line (
    input  wire logic hold_low,
    output wire logic rx_pin
);
    assign rx_pin = !hold_low;
endmodule // remote_line
`default_nettype wire

// ==== testbench/rate_gen_assertions.sv ====
// Purpose: Port-level checks of the bit-rate generator
// Assumes: Write address and data offered together by the master
// Notes:   Bound to rate_gen below
`timescale 1ns/1ps
`default_nettype none
`include "rate_gen_consts.vh"
module rate_gen_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        bit_tick
);
    logic div_q;
    always_ff @(posedge clk)
        if (!rst_b) div_q <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready) div_q <= (s_axi_awaddr == {28'h0, `OFS_DIV_HIGH});
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_tick_spacing: assert property (bit_tick |=> !bit_tick [*3])
        else $error("bit tick too close to previous");
    a_div_restart: assert property ($rose(s_axi_bvalid) && div_q |=> ##1 !bit_tick [*6])
        else $error("tick soon after divisor write");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer timing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_bad_addr: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr[31:4] != 28'h0 |=> ##1 s_axi_bresp == 2'b10)
        else $error("unmapped write not refused");
endmodule // rate_gen_checker
bind rate_gen rate_gen_checker u_chk (.clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .bit_tick(bit_tick));
`default_nettype wire

// ==== testbench/rate_gen_bench.sv ====
// Purpose: Register-driven tests of the bit-rate generator
// Assumes: Divisor word carries high byte in lane 0, low byte in lane 1
// Notes:   Periods counted in clock cycles between ticks
`timescale 1ns/1ps
`default_nettype none
module rate_gen_bench;
    logic        clk = 1'b0, rst_b = 1'b0, hold_low = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic        rx_pin, bit_tick, rx_level;
    int          n_mismatch = 0, n_tests = 0, cycles = 0, p;
    logic [31:0] rd;
    logic [1:0]  rsp;
    // Mode table: control words, divisor word, expected period
    logic [7:0]  tx_t [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h90, 8'h94};
    logic [7:0]  rc_t [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
    logic [31:0] dv_t [6] = '{32'h0205, 32'h0305, 32'h0201, 32'h0300, 32'h0705, 32'h0001};
    int          pe_t [6] = '{192, 64, 4144, 16, 32, 1028};
    logic [31:0] rs_t [4] = '{32'h02, 32'h00, 32'h40, 32'h00};
    always #4 clk = ~clk;
    rate_gen u_dut (.clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .rx_pin(rx_pin), .bit_tick(bit_tick), .rx_level(rx_level));
    remote_line u_far (.hold_low(hold_low), .rx_pin(rx_pin));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        do @(posedge clk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [31:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic period();
        do @(posedge clk); while (!bit_tick);
        p = 0;
        do begin
            @(posedge clk);
            p++;
        end while (!bit_tick);
    endtask
    // Hang guard, well above the longest mode sweep
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd_reg(32'(i * 4));
            check(rd, rs_t[i], "reset value");
        end
        wr(32'h10, 32'hff);
        check({30'h0, rsp}, 32'h2, "unmapped write response");
        rd_reg(32'h10);
        check(rd, 32'h0, "unmapped read data");
        check({30'h0, rsp}, 32'h2, "unmapped read response");
        wr(32'h0, 32'h0);
        rd_reg(32'h0);
        check(rd, 32'h02, "read-only status bit");
        wr(32'h4, 32'h80);
        for (int i = 0; i < 6; i++) begin
            wr(32'h0, {24'h0, tx_t[i]});
            wr(32'h8, {24'h0, rc_t[i]});
            wr(32'hc, dv_t[i]);
            period();
            check(p, pe_t[i], "tick period");
        end
        wr(32'h0, 32'h04);
        wr(32'hc, 32'hff00);
        repeat (40) @(posedge clk);
        wr(32'hc, 32'h0300);
        p = 0;
        do begin
            @(posedge clk);
            p++;
        end while (!bit_tick);
        check({31'h0, p >= 10 && p <= 20}, 32'h1, "restart after divisor write");
        wr(32'h0, 32'h10);
        p = 0;
        repeat (300) begin
            @(posedge clk);
            p += int'(bit_tick);
        end
        check(p, 0, "slave mode ticks");
        wr(32'h0, 32'h00);
        wr(32'h8, 32'h00);
        hold_low <= 1'b1;
        repeat (3) period();
        check({31'h0, rx_level}, 32'h0, "voted level");
        rd_reg(32'h8);
        check({31'h0, rd[6]}, 32'h0, "level status bit");
        wr(32'h0, 32'h04);
        wr(32'h8, 32'h08);
        hold_low <= 1'b0;
        repeat (3) period();
        check({31'h0, rx_level}, 32'h1, "single sample level");
        complete_run();
    end
endmodule // rate_gen_bench
`default_nettype wire
